// File: verilog/pllsr_pkg.sv
// pllsr_pkg: constants for the pll status readback register.
// assumes the serial control port passes the full 10-bit address; the register decodes it itself.
package pllsr_pkg;
  localparam int unsigned PLLSR_W          = 8;
  localparam logic [9:0]  PLLSR_ADDR       = 10'h01f;
  localparam logic [7:0]  PLLSR_RESET      = 8'h00;
  localparam int unsigned BIT_LOCK         = 0;
  localparam int unsigned BIT_PRI_ABOVE    = 1;
  localparam int unsigned BIT_SEC_ABOVE    = 2;
  localparam int unsigned BIT_VCO_ABOVE    = 3;
  localparam int unsigned BIT_SEC_SELECTED = 4;
  localparam int unsigned BIT_HOLDOVER     = 5;
  localparam int unsigned BIT_CAL_DONE     = 6;
  localparam int unsigned BIT_UNUSED       = 7;
endpackage

// File: verilog/pllsr_status.sv
// pllsr_status: read-only status register fed by pll, monitors and lock detect.
// assumes status inputs come from other domains, so each passes two flops.
`timescale 1ns/1ps
`default_nettype none
module pllsr_status
  import pllsr_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               resetn,
  input  wire logic               holdover_active,
  input  wire logic               secondary_reference_selected,
  input  wire logic               vco_above_threshold,
  input  wire logic               secondary_reference_above,
  input  wire logic               primary_reference_above,
  input  wire logic               digital_lock,
  input  wire logic               vco_cal_done,
  input  wire logic               rd_en,
  input  wire logic [9:0]         rd_addr,
  output var  logic [PLLSR_W-1:0] rd_data,
  output var  logic               rd_hit
);

  // raw word built from the monitor levels; still asynchronous here
  logic [PLLSR_W-1:0] raw;











  // resynchronised word; each bit is driven by its own two-flop chain
  wire logic [PLLSR_W-1:0] status;











  // next values of the read port
  logic [PLLSR_W-1:0] next_rd_data;
  logic               next_rd_hit;











  // address compare, shared by the hit flag and the data mux
  function automatic logic pllsr_addr_match(
    input logic       en,
    input logic [9:0] addr
  );
    return en && (addr == PLLSR_ADDR);
  endfunction











  // one place decides which monitor lands on which bit
  function automatic logic [PLLSR_W-1:0] pllsr_pack(
    input logic hold,
    input logic sel,
    input logic vco,
    input logic sec,
    input logic pri,
    input logic lock,
    input logic cal
  );
    logic [PLLSR_W-1:0] word;
    word                   = PLLSR_RESET;
    word[BIT_HOLDOVER]     = hold;
    word[BIT_SEC_SELECTED] = sel;
    word[BIT_VCO_ABOVE]    = vco;
    word[BIT_SEC_ABOVE]    = sec;
    word[BIT_PRI_ABOVE]    = pri;
    word[BIT_LOCK]         = lock;
    word[BIT_CAL_DONE]     = cal;
    word[BIT_UNUSED]       = 1'b0;
    return word;
  endfunction











  // source levels; no write path exists, the register is status only
  always_comb begin
    raw = pllsr_pack(
      holdover_active,
      secondary_reference_selected,
      vco_above_threshold,
      secondary_reference_above,
      primary_reference_above,
      digital_lock,
      vco_cal_done
    );
  end











  // two flops per bit before anything reads it: the monitors run on
  // other clocks, and a single flop could pass metastability to the bus
  genvar g;
  generate
    for (g = 0; g < PLLSR_W; g = g + 1) begin : g_sync
      logic meta;
      logic held;
      logic next_meta;
      logic next_held;

      always_comb begin
        next_meta = raw[g];
        next_held = meta;
      end

      always_ff @(posedge core_clk) begin
        if (!resetn) begin
          meta <= PLLSR_RESET[g];
          held <= PLLSR_RESET[g];
        end else begin
          meta <= next_meta;
          held <= next_held;
        end
      end

      assign status[g] = held;
    end
  endgenerate











  // bits are sampled independently, so a read taken while several
  // monitors move at once may mix old and new levels for one cycle
  always_comb begin
    next_rd_hit  = pllsr_addr_match(rd_en, rd_addr);
    next_rd_data = PLLSR_RESET;
    if (pllsr_addr_match(rd_en, rd_addr)) begin
      next_rd_data = status;
    end
  end











  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rd_data <= PLLSR_RESET;
      rd_hit  <= 1'b0;
    end else begin
      rd_data <= next_rd_data;
      rd_hit  <= next_rd_hit;
    end
  end
















endmodule // pllsr_status
`default_nettype wire

// File: sim/pllsr_assertions.sv
// pllsr_chk: read handshake checks. assumes bind onto pllsr_status.
`timescale 1ns/1ps
`default_nettype none
module pllsr_chk
  import pllsr_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire logic       holdover_active,
  input wire logic       secondary_reference_selected,
  input wire logic       vco_above_threshold,
  input wire logic       secondary_reference_above,
  input wire logic       primary_reference_above,
  input wire logic       digital_lock,
  input wire logic       vco_cal_done,
  input wire logic       rd_en,
  input wire logic       rd_hit,
  input wire logic [9:0] rd_addr,
  input wire logic [7:0] rd_data
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  AST_HIT: assert property (rd_en&&rd_addr==PLLSR_ADDR |=> rd_hit)
    else $error("no hit");
  AST_MISS: assert property (!(rd_en&&rd_addr==PLLSR_ADDR) |=> !rd_hit&&rd_data==PLLSR_RESET)
    else $error("stray data");
  AST_HOLD: assert property (rd_hit |-> rd_data[5]==$past(holdover_active,3))
    else $error("holdover bit wrong");
  AST_SEL: assert property (rd_hit |-> rd_data[4]==$past(secondary_reference_selected,3))
    else $error("selected bit wrong");
  AST_VCO: assert property (rd_hit |-> rd_data[3]==$past(vco_above_threshold,3))
    else $error("vco bit wrong");
  AST_SEC: assert property (rd_hit |-> rd_data[2]==$past(secondary_reference_above,3))
    else $error("secondary bit wrong");
  AST_PRI: assert property (rd_hit |-> rd_data[1]==$past(primary_reference_above,3))
    else $error("primary bit wrong");
  AST_LOCK: assert property (rd_hit |-> rd_data[0]==$past(digital_lock,3))
    else $error("lock bit wrong");
  AST_CAL: assert property (rd_hit |-> rd_data[6]==$past(vco_cal_done,3))
    else $error("calibration bit wrong");
  AST_B7: assert property (!rd_data[7])
    else $error("bit 7 set");
endmodule // pllsr_chk
bind pllsr_status pllsr_chk i_chk(.*);
`default_nettype wire

// File: sim/testbench.sv
// testbench: random status reads. assumes register alone at 0x01f.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,a) begin n_compared++; if ((a)!==(e)) begin num_errors++; $display("mismatch %s exp %h got %h",n,e,a); end end
module testbench;
  import pllsr_pkg::*;
  logic core_clk=0,resetn=0,rd_en=0,holdover_active=0,secondary_reference_selected=0,
    vco_above_threshold=0,secondary_reference_above=0,primary_reference_above=0,
    digital_lock=0,vco_cal_done=0,rd_hit;
  logic [9:0] rd_addr=0; logic [7:0] rd_data; logic [6:0] v;
  int num_errors=0,n_compared=0,seed=32'h4ab4,cyc=0;
  pllsr_status i_dut(.*);
  always #2 core_clk=~core_clk;
  always @(posedge core_clk) if (++cyc>2000) begin num_errors++; complete_run; end
  function logic [7:0] exp_f(logic [6:0] x); return {1'b0,x}; endfunction
  task rd(logic [9:0] a,logic [7:0] e);
    @(posedge core_clk) rd_en<=1; rd_addr<=a; @(posedge core_clk) rd_en<=0; #1;
    `CHK("rd_data",e,rd_data)
    `CHK("rd_hit",a==PLLSR_ADDR,rd_hit)
  endtask
  task complete_run; $display("compared %0d errors %0d",n_compared,num_errors);
    if (num_errors==0&&n_compared>0) $display("All checks passed"); else $display("Checks failed");
    $finish; endtask
  initial begin
    repeat (3) @(posedge core_clk); resetn<=1;
    for (int i=0;i<20;i++) begin
      v=i==0?7'h7f:i==1?7'h00:7'($random(seed));
      @(posedge core_clk) {vco_cal_done,holdover_active,secondary_reference_selected,
        vco_above_threshold,secondary_reference_above,primary_reference_above,digital_lock}<=v;
      repeat (4) @(posedge core_clk); // two sync flops, margin
      rd(PLLSR_ADDR,exp_f(v));
      rd(10'($random(seed))|10'h020,8'h00);
      $display("test %0d done",i);
    end
    complete_run;
  end
endmodule // testbench
`default_nettype wire
